// ---- shared/gain_pkg.sv ----
package gain_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MASTER = 8'h00;
  localparam logic [7:0] OFS_TRIM   = 8'h04;
  localparam logic [7:0] OFS_MIXER  = 8'h08;
  localparam logic [7:0] OFS_EQ     = 8'h0c;
  localparam logic [7:0] OFS_GAIN_A = 8'h10;
  localparam logic [7:0] OFS_GAIN_B = 8'h14;

  // Reset codes: every path at 0 dB, mixer positive polarity
  localparam logic [7:0] RST_MASTER = 8'h30;
  localparam logic [5:0] RST_TRIM   = 6'h00;
  localparam logic [7:0] RST_MIXER  = 8'h24;
  localparam logic [4:0] RST_EQ     = 5'h00;

  // Master volume
  localparam logic [7:0] MV_TOP    = 8'h0c;
  localparam logic [7:0] MV_ZERO   = 8'h30;
  localparam logic [7:0] MV_BOTTOM = 8'hbc;
  // Trim: signed half-dB steps
  localparam logic [5:0] TRIM_MAX  = 6'h18;
  localparam logic [5:0] TRIM_MIN  = 6'h28;
  // Mixer: gain in the lower seven bits, polarity in bit 7
  localparam logic [6:0] MIX_ZERO  = 7'h24;
  localparam logic [6:0] MIX_LAST  = 7'h78;
  localparam int         MIX_POL   = 7;
  // EQ: signed one-dB steps
  localparam logic [4:0] EQ_MAX    = 5'h0c;
  localparam logic [4:0] EQ_MIN    = 5'h14;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Decoded gains in signed half-dB units, except EQ in signed one-dB units
  typedef struct packed {
    logic signed [8:0] master_hdb;
    logic signed [5:0] trim_hdb;
    logic signed [7:0] mixer_hdb;
    logic              mixer_invert;
    logic              mixer_mute;
    logic signed [5:0] eq_db;
  } gains_s;

endpackage

// ---- design/signed_clamp.sv ----
`timescale 1ns/1ps
// Clamps a signed code to [lo, hi]
module signed_clamp #(
  parameter int W = 6,
  parameter logic signed [W-1:0] HI = '0,
  parameter logic signed [W-1:0] LO = '0
) (
  // Code
  input  wire logic signed [W-1:0] code,
  // Clamped
  output      logic signed [W-1:0] value
);
  wire hi_over = code > HI;
  wire lo_under = code < LO;
  assign value = hi_over ? HI : (lo_under ? LO : code);
endmodule // signed_clamp

// ---- design/step_down.sv ----
`timescale 1ns/1ps
// Gain in half-dB from a code counting down from a zero-dB point
module step_down #(
  parameter int W = 8,
  parameter logic [W-1:0] ZERO = '0,
  parameter logic [W-1:0] LAST = '0
) (
  // Code
  input  wire logic [W-1:0]      code,
  // Gain, half-dB units
  output      logic signed [W:0] hdb
);
  wire [W-1:0] capped = (code > LAST) ? LAST : code;
  assign hdb = $signed({1'b0, ZERO}) - $signed({1'b0, capped});
endmodule // step_down

// ---- design/audio_gain_code_decoder.sv ----
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module audio_gain_code_decoder
  import gain_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Decoded gains
  output gain_pkg::gains_s gains
);
  import gain_pkg::*;

  logic [7:0]  master_q;
  logic [5:0]  trim_q;
  logic [7:0]  mixer_q;
  logic [4:0]  eq_q;
  logic [7:0]  aw_addr_q;
  logic        aw_have_q;
  logic [7:0]  w_data_q;
  logic        w_strb0_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  gains_s      gains_q;

  // Write channel capture; address and data may come in either order
  wire aw_take = s_axi_awvalid && !aw_have_q && !bvalid_q;
  wire w_take  = s_axi_wvalid && !w_have_q && !bvalid_q;
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;

  wire [7:0] wa = aw_addr_q;
  wire wr_master = do_write && w_strb0_q && (wa == OFS_MASTER);
  wire wr_trim   = do_write && w_strb0_q && (wa == OFS_TRIM);
  wire wr_mixer  = do_write && w_strb0_q && (wa == OFS_MIXER);
  wire wr_eq     = do_write && w_strb0_q && (wa == OFS_EQ);
  wire wr_known  = (wa == OFS_MASTER) || (wa == OFS_TRIM) || (wa == OFS_MIXER)
                || (wa == OFS_EQ) || (wa == OFS_GAIN_A) || (wa == OFS_GAIN_B);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_addr_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb0_q <= 1'b0;
      w_have_q  <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (w_take)
      begin
        w_data_q  <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
        w_have_q  <= 1'b1;
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Code registers; only the low byte lane carries a code
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      master_q <= RST_MASTER;
      trim_q   <= RST_TRIM;
      mixer_q  <= RST_MIXER;
      eq_q     <= RST_EQ;
    end
    else
    begin
      if (wr_master)
        master_q <= w_data_q;
      if (wr_trim)
        trim_q <= w_data_q[5:0];
      if (wr_mixer)
        mixer_q <= w_data_q;
      if (wr_eq)
        eq_q <= w_data_q[4:0];
    end
  end

  // Master: count down from 0x30; codes below 0x0C stay at +18
  wire [7:0] mv_floor = (master_q < MV_TOP) ? MV_TOP : master_q;
  logic signed [8:0] mv_hdb;
  step_down #(.W(8), .ZERO(MV_ZERO), .LAST(MV_BOTTOM)) u_master (
    .code (mv_floor),
    .hdb  (mv_hdb)
  );

  logic signed [5:0] trim_hdb;
  signed_clamp #(.W(6), .HI(TRIM_MAX), .LO(TRIM_MIN)) u_trim (
    .code  (trim_q),
    .value (trim_hdb)
  );

  // Mixer: gain from the low seven bits, polarity from the top bit
  logic signed [7:0] mix_hdb;
  step_down #(.W(7), .ZERO(MIX_ZERO), .LAST(MIX_LAST)) u_mixer (
    .code (mixer_q[6:0]),
    .hdb  (mix_hdb)
  );
  wire mix_mute   = mixer_q[6:0] > MIX_LAST;
  wire mix_invert = mixer_q[MIX_POL];

  logic signed [4:0] eq_clamped;
  signed_clamp #(.W(5), .HI(EQ_MAX), .LO(EQ_MIN)) u_eq (
    .code  (eq_q),
    .value (eq_clamped)
  );

  gains_s gains_d;
  assign gains_d.master_hdb   = mv_hdb;
  assign gains_d.trim_hdb     = trim_hdb;
  assign gains_d.mixer_hdb    = mix_mute ? 8'sh00 : mix_hdb;
  assign gains_d.mixer_invert = mix_invert;
  assign gains_d.mixer_mute   = mix_mute;
  assign gains_d.eq_db        = {eq_clamped[4], eq_clamped};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      gains_q <= '0;
    else
      gains_q <= gains_d;
  end

  assign gains = gains_q;

  // Read channel: one outstanding read
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire ar_take = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ra)
      OFS_MASTER: rd_mux = {24'h000000, master_q};
      OFS_TRIM:   rd_mux = {26'h0000000, trim_q};
      OFS_MIXER:  rd_mux = {24'h000000, mixer_q};
      OFS_EQ:     rd_mux = {27'h0000000, eq_q};
      OFS_GAIN_A: rd_mux = {16'h0000, gains_q.trim_hdb, 1'b0, gains_q.master_hdb};
      OFS_GAIN_B: rd_mux = {8'h00, 2'b00, gains_q.eq_db, 6'h00,
                            gains_q.mixer_mute, gains_q.mixer_invert, gains_q.mixer_hdb};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // audio_gain_code_decoder

// ---- tb/audio_gain_code_decoder_monitor.sv ----
`timescale 1ns/1ps
module audio_gain_code_decoder_monitor
  import gain_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Bus handshakes
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // Decoded gains
  input wire gain_pkg::gains_s gains
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_master_span:
    assert property (gains.master_hdb <= 36 && gains.master_hdb >= -140)
    else $error("master gain beyond span");
  a_trim_clamp:
    assert property (gains.trim_hdb <= 24 && gains.trim_hdb >= -24)
    else $error("trim gain beyond span");
  a_eq_clamp:
    assert property (gains.eq_db <= 12 && gains.eq_db >= -12)
    else $error("eq gain beyond span");
  a_mute_silent:
    assert property (gains.mixer_mute |-> gains.mixer_hdb == 0)
    else $error("muted mixer carries gain");
  // Gains follow a write response by exactly one cycle
  a_gain_cause:
    assert property ($changed(gains) |-> $past(s_axi_bvalid))
    else $error("gains moved without a write");
  a_read_turn:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_data_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // audio_gain_code_decoder_monitor

bind audio_gain_code_decoder audio_gain_code_decoder_monitor i_audio_gain_code_decoder_monitor (.*);

// ---- tb/audio_gain_code_decoder_tb.sv ----
`timescale 1ns/1ps
module audio_gain_code_decoder_tb;
  import gain_pkg::*;
  logic        sys_clk = '0;
  logic        rstn = '0;
  logic [7:0]  s_axi_awaddr = '0;
  logic [7:0]  s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, r;
  gains_s      gains, ex;
  int          err_total = 0, checked = 0, seed = 53, n;
  logic [7:0]  m [4] = '{8'hff, 8'h3f, 8'hff, 8'h1f};
  logic [7:0]  mv [8] = '{8'h00, 8'h0b, 8'h0c, 8'h30, 8'h31, 8'hbc, 8'hbd, 8'hff};
  logic [7:0]  tc [9] = '{8'h00, 8'h01, 8'h18, 8'h19, 8'h1f, 8'h20, 8'h27, 8'h28, 8'h3f};
  logic [7:0]  mx [10] = '{8'h00, 8'h24, 8'h78, 8'h79, 8'h7f, 8'h80, 8'ha4, 8'hf8, 8'hf9, 8'hff};
  logic [7:0]  ec [8] = '{8'h00, 8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h13, 8'h14, 8'h1f};

  audio_gain_code_decoder i_audio_gain_code_decoder (.*);

  always #20 sys_clk = ~sys_clk;

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic int lim(input int v, input int lo, input int hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction

  // Ready is raised only after valid is seen, so the slave must hold its answer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, tv, rdy;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    do
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      tv = w ? s_axi_bvalid : s_axi_rvalid;
      rdy = w ? s_axi_bready : s_axi_rready;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= '0;
      if (tw) s_axi_wvalid <= '0;
      if (tr) s_axi_arvalid <= '0;
      if (tv && !rdy) s_axi_bready <= w;
      if (tv && !rdy) s_axi_rready <= !w;
      n++;
    end
    while (!(tv && rdy) && n < 40);
    s_axi_bready <= '0;
    s_axi_rready <= '0;
    if (!(tv && rdy))
    begin
      err_total++;
      tally_and_finish;
    end
  endtask

  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
    case (a)
      OFS_MASTER: ex.master_hdb = 9'(lim(48 - int'(d[7:0]), -140, 36));
      OFS_TRIM:   ex.trim_hdb = 6'(lim(int'($signed(d[5:0])), -24, 24));
      OFS_EQ:     ex.eq_db = 6'(lim(int'($signed(d[4:0])), -12, 12));
      default:
      begin
        ex.mixer_invert = d[7];
        ex.mixer_mute = d[6:0] > 7'h78;
        ex.mixer_hdb = ex.mixer_mute ? 8'h00 : 8'(36 - int'(d[6:0]));
      end
    endcase
    @(negedge sys_clk);
    chk("gains", {2'h0, gains}, {2'h0, ex});
    xfer(1'h0, a, 32'h0);
    chk("readback", rd, {24'h0, d[7:0] & m[a[3:2]]});
  endtask

  initial
  begin
    ex = '0;
    repeat (4) @(posedge sys_clk);
    rstn <= '1;
    @(negedge sys_clk);
    chk("reset gains", {2'h0, gains}, 32'h0);
    foreach (mv[i]) wc(OFS_MASTER, {24'h0, mv[i]});
    foreach (tc[i]) wc(OFS_TRIM, {24'h0, tc[i]});
    foreach (mx[i]) wc(OFS_MIXER, {24'h0, mx[i]});
    foreach (ec[i]) wc(OFS_EQ, {24'h0, ec[i]});
    $display("code tables done");
    repeat (40)
    begin
      r = $random(seed);
      wc({4'h0, r[1:0], 2'h0}, $random(seed));
    end
    $display("random codes done");
    xfer(1'h1, 8'h20, 32'h5);
    chk("unmapped bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    xfer(1'h0, 8'h20, 32'h0);
    chk("unmapped rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", rd, 32'h0);
    wc(OFS_MASTER, 32'h30);
    s_axi_wstrb <= 4'he;
    xfer(1'h1, OFS_MASTER, 32'h0c);
    s_axi_wstrb <= 4'hf;
    chk("masked bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
    repeat (2) @(negedge sys_clk);
    chk("masked gains", {2'h0, gains}, {2'h0, ex});
    xfer(1'h0, OFS_MASTER, 32'h0);
    chk("masked readback", rd, 32'h30);
    $display("bus errors done");
    tally_and_finish;
  end
endmodule // audio_gain_code_decoder_tb
